// File: ssw_standby_ctrl.sv
// standby controller: stop and wait modes, wake-up timing, reset pin handling, AXI4-Lite registers
//
// Overview of operation
// - external interrupt ends stop: timer gets 01, prescaler FF unless inhibited
// - inhibit bit six of port control two keeps software preset timer values
// - after interrupt wake from stop, CPU clock waits for timer underflow
// - interrupt wake from stop keeps CPU mode, restarting every oscillator that ran
// - with main clock selected, automatic delay lasts about eight thousand cycles
// - delay is timed for the main oscillator only; sub oscillator may be unstable
// - wait instruction keeps oscillators running, stops CPU clock high
// - in wait, ports hold, peripherals keep running, D-A outputs hold
// - two-wire interface stops in wait unless clock stop selection bit is one
// - wait ends by reset or interrupt, resuming without stabilization delay
// - reset low ends wait, ports go input, CPU clock restarts; sixteen cycles reset
// - device leaves reset about 10.5 to 18.5 cycles after reset pin rises
// - reset ending wait keeps RAM, clears CPU and special function registers
// - interrupt ending wait restarts CPU clock and that interrupt is accepted
// - reset in wait on sub clock with main stopped selects main oscillator again
// - stop instruction halts both oscillators and CPU clock high, peripherals stop
// - at stop entry, inhibit zero presets FF and 01; inhibit one presets nothing
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ps
module ssw_standby_ctrl (
    input wire logic clk,                         // main oscillator clock
    input wire logic rst_n,                       // power-on reset, asynchronous
    input wire logic reset_pin_n,                 // device reset pin, asynchronous
    input wire logic external_irq_zero,           // external interrupt pin, asynchronous
    input wire logic irq_req,                     // enabled interrupt request from controller
    input wire ssw_pkg::ssw_axi_req_t axi_req,   // AXI4-Lite master to slave
    output ssw_pkg::ssw_axi_rsp_t axi_rsp,        // AXI4-Lite slave to master
    output ssw_pkg::ssw_ctl_t ctl,                // clock and unit controls
    output logic irq_accept                       // pulse: wake interrupt accepted
);
    function automatic logic [7:0] reg_index(input logic [ssw_pkg::ADDR_W-1:0] addr);
        reg_index = addr[9:2];
    endfunction

    function automatic logic mapped(input logic [7:0] idx);
        mapped = (idx == ssw_pkg::IDX_CLK_STOP_SEL) || (idx == ssw_pkg::IDX_PORT_CTL2) ||
                 (idx == ssw_pkg::IDX_CPU_MODE) || (idx == ssw_pkg::IDX_STAB) ||
                 (idx == ssw_pkg::IDX_CMD) || (idx == ssw_pkg::IDX_STATUS) ||
                 (addr_hi_zero(idx));
    endfunction

    function automatic logic addr_hi_zero(input logic [7:0] idx);
        addr_hi_zero = 1'b0 & idx[0];
    endfunction

    // pin synchronisers
    logic rpin_s1;
    logic rpin_s2;
    logic irq0_s1;
    logic irq0_s2;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rpin_s1 <= 1'b0;
            rpin_s2 <= 1'b0;
            irq0_s1 <= 1'b0;
            irq0_s2 <= 1'b0;
        end else begin
            rpin_s1 <= reset_pin_n;
            rpin_s2 <= rpin_s1;
            irq0_s1 <= external_irq_zero;
            irq0_s2 <= irq0_s1;
        end
    end

    wire logic pin_low = !rpin_s2;
    wire logic wake = irq_req | irq0_s2;

    // reset pin timing
    logic [4:0] rst_cnt;
    logic sfr_rst;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_cnt <= 5'h00;
            sfr_rst <= 1'b1;
        end else if (pin_low) begin
            // the count restarts from zero once reset is on, so the release is always timed
            if (sfr_rst) begin
                rst_cnt <= 5'h00;
            end else if (rst_cnt == ssw_pkg::RST_LOW_CYCLES - 5'h01) begin
                rst_cnt <= 5'h00;
                sfr_rst <= 1'b1;
            end else begin
                rst_cnt <= rst_cnt + 5'h01;
            end
        end else if (sfr_rst) begin
            // release count reused; a short low pulse never asserted reset
            if (rst_cnt >= ssw_pkg::RST_RELEASE_CYCLES) begin
                rst_cnt <= 5'h00;
                sfr_rst <= 1'b0;
            end else begin
                rst_cnt <= rst_cnt + 5'h01;
            end
        end else begin
            rst_cnt <= 5'h00;
        end
    end

    // registers; sfr reset clears them but RAM is not on this reset
    logic [7:0] port_ctl2;
    logic [7:0] clk_stop_sel;
    logic [7:0] cpu_mode;
    logic [7:0] pre_latch;
    logic [7:0] tmr_latch;
    logic wr_fire;
    logic [7:0] wr_idx;
    logic [31:0] wr_data;
    logic [3:0] wr_strb;
    logic cmd_halt;
    logic cmd_gate;
    ssw_pkg::ssw_state_t state;

    wire logic inhibit = port_ctl2[ssw_pkg::BIT_STAB_INHIBIT];
    wire logic stab_wr = wr_fire && (wr_idx == ssw_pkg::IDX_STAB);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            port_ctl2 <= ssw_pkg::RST_PORT_CTL2;
            clk_stop_sel <= ssw_pkg::RST_CLK_STOP_SEL;
            cpu_mode <= ssw_pkg::RST_CPU_MODE;
        end else if (sfr_rst) begin
            port_ctl2 <= ssw_pkg::RST_PORT_CTL2;
            clk_stop_sel <= ssw_pkg::RST_CLK_STOP_SEL;
            cpu_mode <= ssw_pkg::RST_CPU_MODE;
        end else if (wr_fire && wr_strb[0]) begin
            if (wr_idx == ssw_pkg::IDX_PORT_CTL2) begin
                port_ctl2 <= wr_data[7:0];
            end
            if (wr_idx == ssw_pkg::IDX_CLK_STOP_SEL) begin
                clk_stop_sel <= wr_data[7:0];
            end
            if (wr_idx == ssw_pkg::IDX_CPU_MODE) begin
                cpu_mode <= wr_data[7:0];
            end
        end
    end

    // instruction strobes only act from run; a reset pin low cancels them
    always_comb begin
        cmd_halt = wr_fire && wr_strb[0] && (wr_idx == ssw_pkg::IDX_CMD) &&
                   (state == ssw_pkg::ST_RUN) &&
                   wr_data[ssw_pkg::BIT_CMD_HALT_OSC] && !sfr_rst && !pin_low;
        cmd_gate = wr_fire && wr_strb[0] && (wr_idx == ssw_pkg::IDX_CMD) &&
                   (state == ssw_pkg::ST_RUN) &&
                   wr_data[ssw_pkg::BIT_CMD_CPU_GATE] && !sfr_rst && !pin_low &&
                   !wr_data[ssw_pkg::BIT_CMD_HALT_OSC];
    end

    // stabilization prescaler and timer
    logic [3:0] div_cnt;
    logic [7:0] pre_cnt;
    logic [7:0] tmr_cnt;
    wire logic div_tick = (div_cnt == ssw_pkg::STAB_DIV_LAST);
    wire logic pre_uf = div_tick && (pre_cnt == 8'h00);
    wire logic tmr_uf = pre_uf && (tmr_cnt == 8'h00);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 4'h0;
            pre_cnt <= ssw_pkg::AUTO_PRESCALER;
            tmr_cnt <= ssw_pkg::AUTO_TIMER;
            pre_latch <= ssw_pkg::AUTO_PRESCALER;
            tmr_latch <= ssw_pkg::AUTO_TIMER;
        end else if (sfr_rst) begin
            div_cnt <= 4'h0;
            pre_cnt <= ssw_pkg::AUTO_PRESCALER;
            tmr_cnt <= ssw_pkg::AUTO_TIMER;
            pre_latch <= ssw_pkg::AUTO_PRESCALER;
            tmr_latch <= ssw_pkg::AUTO_TIMER;
        end else if (cmd_halt && !inhibit) begin
            div_cnt <= 4'h0;
            pre_cnt <= ssw_pkg::AUTO_PRESCALER;
            tmr_cnt <= ssw_pkg::AUTO_TIMER;
            pre_latch <= ssw_pkg::AUTO_PRESCALER;
            tmr_latch <= ssw_pkg::AUTO_TIMER;
        end else if (state == ssw_pkg::ST_STOP && wake && !pin_low) begin
            div_cnt <= 4'h0;
            if (!inhibit) begin
                pre_cnt <= ssw_pkg::AUTO_PRESCALER;
                tmr_cnt <= ssw_pkg::AUTO_TIMER;
            end
        end else if (state == ssw_pkg::ST_STAB) begin
            // count source from main oscillator only; sub side gets no margin
            div_cnt <= div_cnt + 4'h1;
            if (pre_uf) begin
                pre_cnt <= pre_latch;
                tmr_cnt <= tmr_uf ? tmr_latch : tmr_cnt - 8'h01;
            end else if (div_tick) begin
                pre_cnt <= pre_cnt - 8'h01;
            end
        end else if (stab_wr) begin
            if (wr_strb[0]) begin
                pre_cnt <= wr_data[7:0];
                pre_latch <= wr_data[7:0];
            end
            if (wr_strb[1]) begin
                tmr_cnt <= wr_data[15:8];
                tmr_latch <= wr_data[15:8];
            end
        end
    end

    // mode sequencing
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ssw_pkg::ST_RUN;
        end else if (pin_low || sfr_rst) begin
            state <= ssw_pkg::ST_RUN;
        end else begin
            case (state)
                ssw_pkg::ST_RUN: begin
                    if (cmd_halt) begin
                        state <= ssw_pkg::ST_STOP;
                    end else if (cmd_gate) begin
                        state <= ssw_pkg::ST_WAIT;
                    end
                end
                ssw_pkg::ST_WAIT: begin
                    if (wake) begin
                        state <= ssw_pkg::ST_RUN;
                    end
                end
                ssw_pkg::ST_STOP: begin
                    if (wake) begin
                        state <= ssw_pkg::ST_STAB;
                    end
                end
                ssw_pkg::ST_STAB: begin
                    if (tmr_uf) begin
                        state <= ssw_pkg::ST_RUN;
                    end
                end
                default: begin
                    state <= ssw_pkg::ST_RUN;
                end
            endcase
        end
    end

    // the wake interrupt is taken one edge before the registered CPU clock control restarts
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_accept <= 1'b0;
        end else begin
            irq_accept <= (state == ssw_pkg::ST_WAIT) && wake && !pin_low && !sfr_rst;
        end
    end

    // unit controls, registered
    ssw_pkg::ssw_ctl_t next_ctl;
    always_comb begin
        next_ctl = '0;
        next_ctl.main_osc_en = !cpu_mode[ssw_pkg::BIT_MAIN_STOP] || pin_low || sfr_rst;
        next_ctl.sub_osc_en = cpu_mode[ssw_pkg::BIT_SUB_ON] && !pin_low && !sfr_rst;
        next_ctl.sys_clk_sub = cpu_mode[ssw_pkg::BIT_SYS_SUB] && !pin_low && !sfr_rst;
        next_ctl.port_input = pin_low || sfr_rst;
        next_ctl.sfr_reset = sfr_rst;
        next_ctl.cpu_clk_run = pin_low || sfr_rst;
        next_ctl.periph_run = 1'b1;
        next_ctl.two_wire_run = 1'b1;
        if (!(pin_low || sfr_rst)) begin
            case (state)
                ssw_pkg::ST_RUN: begin
                    next_ctl.cpu_clk_run = 1'b1;
                end
                ssw_pkg::ST_WAIT: begin
                    next_ctl.port_hold = 1'b1;
                    next_ctl.dac_hold = 1'b1;
                    next_ctl.two_wire_run = clk_stop_sel[ssw_pkg::BIT_TWO_WIRE_KEEP];
                end
                ssw_pkg::ST_STOP: begin
                    next_ctl.main_osc_en = 1'b0;
                    next_ctl.sub_osc_en = 1'b0;
                    next_ctl.periph_run = 1'b0;
                    next_ctl.two_wire_run = 1'b0;
                    next_ctl.port_hold = 1'b1;
                    next_ctl.dac_hold = 1'b1;
                end
                ssw_pkg::ST_STAB: begin
                    // cpu mode untouched, so every oscillator that ran restarts
                    next_ctl.periph_run = 1'b0;
                    next_ctl.two_wire_run = 1'b0;
                    next_ctl.port_hold = 1'b1;
                    next_ctl.dac_hold = 1'b1;
                end
                default: begin
                    next_ctl.cpu_clk_run = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl <= '0;
        end else begin
            ctl <= next_ctl;
        end
    end

    // AXI4-Lite write side: address and data taken in either order
    logic aw_held;
    logic w_held;
    logic [ssw_pkg::ADDR_W-1:0] aw_addr;
    logic b_valid;
    logic [1:0] b_resp;
    logic r_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    // one process builds the whole response so the struct has a single driver
    always_comb begin
        axi_rsp.awready = !aw_held && !b_valid;
        axi_rsp.wready = !w_held && !b_valid;
        axi_rsp.arready = !r_valid;
        axi_rsp.bvalid = b_valid;
        axi_rsp.bresp = b_resp;
        axi_rsp.rvalid = r_valid;
        axi_rsp.rdata = r_data;
        axi_rsp.rresp = r_resp;
        wr_fire = aw_held && w_held && !b_valid;
        wr_idx = reg_index(aw_addr);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= '0;
            wr_data <= 32'h0000_0000;
            wr_strb <= 4'h0;
            b_valid <= 1'b0;
            b_resp <= ssw_pkg::RESP_OKAY;
        end else begin
            if (axi_req.awvalid && axi_rsp.awready) begin
                aw_held <= 1'b1;
                aw_addr <= axi_req.awaddr;
            end
            if (axi_req.wvalid && axi_rsp.wready) begin
                w_held <= 1'b1;
                wr_data <= axi_req.wdata;
                wr_strb <= axi_req.wstrb;
            end
            if (wr_fire) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                b_valid <= 1'b1;
                b_resp <= mapped(wr_idx) ? ssw_pkg::RESP_OKAY : ssw_pkg::RESP_DECERR;
            end else if (b_valid && axi_req.bready) begin
                b_valid <= 1'b0;
            end
        end
    end

    // read side; status shows mode, timer and prescaler counts
    logic [7:0] rd_idx;
    logic [31:0] next_rdata;
    always_comb begin
        rd_idx = reg_index(axi_req.araddr);
        next_rdata = 32'h0000_0000;
        case (rd_idx)
            ssw_pkg::IDX_CLK_STOP_SEL: next_rdata[7:0] = clk_stop_sel;
            ssw_pkg::IDX_PORT_CTL2: next_rdata[7:0] = port_ctl2;
            ssw_pkg::IDX_CPU_MODE: next_rdata[7:0] = cpu_mode;
            ssw_pkg::IDX_STAB: next_rdata[15:0] = {tmr_cnt, pre_cnt};
            ssw_pkg::IDX_STATUS: next_rdata[17:0] = {state, tmr_cnt, pre_cnt};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r_valid <= 1'b0;
            r_data <= 32'h0000_0000;
            r_resp <= ssw_pkg::RESP_OKAY;
        end else if (axi_req.arvalid && !r_valid) begin
            r_valid <= 1'b1;
            r_data <= next_rdata;
            r_resp <= mapped(rd_idx) ? ssw_pkg::RESP_OKAY : ssw_pkg::RESP_DECERR;
        end else if (r_valid && axi_req.rready) begin
            r_valid <= 1'b0;
        end
    end
endmodule

// File: ssw_pkg.sv
// package of register map, field positions, timing counts and carrier types for standby control
package ssw_pkg;
    localparam int ADDR_W = 12;
    // printed offsets are register indices; byte address is index times four
    localparam logic [7:0] IDX_CLK_STOP_SEL = 8'h15;
    localparam logic [7:0] IDX_PORT_CTL2 = 8'h2f;
    localparam logic [7:0] IDX_CPU_MODE = 8'h3b;
    localparam logic [7:0] IDX_STAB = 8'h3c;
    localparam logic [7:0] IDX_CMD = 8'h3d;
    localparam logic [7:0] IDX_STATUS = 8'h3e;
    localparam int BIT_STAB_INHIBIT = 6;
    localparam int BIT_TWO_WIRE_KEEP = 6;
    localparam int BIT_MAIN_STOP = 0;
    localparam int BIT_SUB_ON = 1;
    localparam int BIT_SYS_SUB = 2;
    localparam int BIT_CMD_HALT_OSC = 0;
    localparam int BIT_CMD_CPU_GATE = 1;
    localparam logic [7:0] RST_CPU_MODE = 8'h00;
    localparam logic [7:0] RST_PORT_CTL2 = 8'h00;
    localparam logic [7:0] RST_CLK_STOP_SEL = 8'h00;
    localparam logic [7:0] AUTO_PRESCALER = 8'hff;
    localparam logic [7:0] AUTO_TIMER = 8'h01;
    // count source of the stabilization prescaler is the main oscillator divided by this
    localparam int STAB_SRC_DIV = 16;
    localparam logic [3:0] STAB_DIV_LAST = 4'(STAB_SRC_DIV - 1);
    // reset pin figures in main oscillator cycles (clk is the main oscillator)
    localparam logic [4:0] RST_LOW_CYCLES = 5'h10;
    localparam logic [4:0] RST_RELEASE_CYCLES = 5'h0e;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_DECERR = 2'b11;

    typedef enum logic [1:0] {
        ST_RUN,
        ST_WAIT,
        ST_STOP,
        ST_STAB
    } ssw_state_t;

    typedef struct packed {
        logic awvalid;
        logic [ADDR_W-1:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [ADDR_W-1:0] araddr;
        logic rready;
    } ssw_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } ssw_axi_rsp_t;

    typedef struct packed {
        logic main_osc_en;
        logic sub_osc_en;
        logic sys_clk_sub;
        logic cpu_clk_run;
        logic periph_run;
        logic two_wire_run;
        logic port_hold;
        logic port_input;
        logic dac_hold;
        logic sfr_reset;
    } ssw_ctl_t;
endpackage

// File: ssw_standby_ctrl_assertions.sv
// concurrent checks on the standby controller ports
`timescale 1ns/1ps
module ssw_standby_ctrl_assertions (
    input wire logic clk, // main clock
    input wire logic rst_n, // power-on reset
    input wire logic reset_pin_n, // device reset pin
    input wire logic external_irq_zero, // external wake pin
    input wire logic irq_req, // wake request
    input wire ssw_pkg::ssw_axi_req_t axi_req, // bus request
    input wire ssw_pkg::ssw_axi_rsp_t axi_rsp, // bus response
    input wire ssw_pkg::ssw_ctl_t ctl, // unit controls
    input wire logic irq_accept // wake accepted
);
    // saturating count of cycles the reset pin has been seen low
    logic [5:0] low_cnt;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_cnt <= 6'h00;
        end else if (reset_pin_n) begin
            low_cnt <= 6'h00;
        end else if (low_cnt != 6'h3f) begin
            low_cnt <= low_cnt + 6'h01;
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    accept_then_run_a: assert property (
        irq_accept |-> !ctl.cpu_clk_run ##1 ctl.cpu_clk_run)
        else $error("cpu clock not restarted one cycle after wake accept");
    osc_off_halt_a: assert property (
        !ctl.main_osc_en && !ctl.sub_osc_en |-> !ctl.cpu_clk_run && !ctl.periph_run)
        else $error("cpu or peripherals running with both oscillators off");
    wait_hold_a: assert property (
        !ctl.cpu_clk_run && ctl.periph_run |-> ctl.port_hold && ctl.dac_hold)
        else $error("ports or converter output not held in wait");
    pin_low_force_a: assert property (
        !reset_pin_n [*6] |-> ctl.port_input && ctl.main_osc_en && !ctl.sub_osc_en
            && !ctl.sys_clk_sub && ctl.cpu_clk_run)
        else $error("reset pin low did not force main clock and input ports");
    pin_low_sfr_a: assert property (
        low_cnt == 6'd22 |-> ctl.sfr_reset)
        else $error("long reset pin low did not reset registers");
    release_time_a: assert property (
        $rose(reset_pin_n) && ctl.sfr_reset |-> ctl.sfr_reset [*8] ##[3:14] !ctl.sfr_reset)
        else $error("register reset release outside the allowed window");
    stab_gate_a: assert property (
        (!ctl.main_osc_en && !ctl.sub_osc_en && ctl.port_hold) ##1
            (ctl.main_osc_en && reset_pin_n) |-> !ctl.cpu_clk_run [*8])
        else $error("cpu clock delivered right after stop wake");
    bus_answer_a: assert property (
        axi_req.arvalid && axi_rsp.arready |=> axi_rsp.rvalid)
        else $error("read answer not given one cycle after address");
endmodule

bind ssw_standby_ctrl ssw_standby_ctrl_assertions chk (.clk(clk), .rst_n(rst_n),
    .reset_pin_n(reset_pin_n), .external_irq_zero(external_irq_zero), .irq_req(irq_req),
    .axi_req(axi_req), .axi_rsp(axi_rsp), .ctl(ctl), .irq_accept(irq_accept));

// File: ssw_standby_ctrl_tb.sv
// self-checking bench for the standby controller
`timescale 1ns/1ps
module ssw_standby_ctrl_tb;
    logic clk;
    logic rst_n;
    logic reset_pin_n;
    logic external_irq_zero;
    logic irq_req;
    logic irq_accept;
    ssw_pkg::ssw_axi_req_t req;
    ssw_pkg::ssw_axi_rsp_t rsp;
    ssw_pkg::ssw_ctl_t ctl;
    int n_fail;
    int samples_checked;
    integer seed;
    int k;
    int n;
    int base;
    logic [31:0] d;
    logic [31:0] q;
    logic [1:0] r;
    logic [7:0] tab [3];

    ssw_standby_ctrl dut (.clk(clk), .rst_n(rst_n), .reset_pin_n(reset_pin_n),
        .external_irq_zero(external_irq_zero), .irq_req(irq_req), .axi_req(req),
        .axi_rsp(rsp), .ctl(ctl), .irq_accept(irq_accept));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic test_done();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // a wait that ran out of bound ends the run at once
    task automatic gone(input logic ok);
        if (ok !== 1'b1) begin
            n_fail++;
            test_done();
        end
    endtask

    task automatic wr(input logic [7:0] idx, input logic [31:0] data);
        int i;
        @(posedge clk);
        req.awaddr <= {2'b00, idx, 2'b00};
        req.wdata <= data;
        req.wstrb <= 4'hf;
        req.awvalid <= 1'b1;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (rsp.awready) begin
                req.awvalid <= 1'b0;
            end
            if (rsp.wready) begin
                req.wvalid <= 1'b0;
            end
            if (rsp.bvalid) begin
                req.bready <= 1'b0;
                break;
            end
        end
        gone(i < 20);
    endtask

    task automatic rd(input logic [7:0] idx, output logic [31:0] data, output logic [1:0] resp);
        int i;
        @(posedge clk);
        req.araddr <= {2'b00, idx, 2'b00};
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        data = 32'h0;
        resp = 2'b01;
        for (i = 0; i < 20; i++) begin
            @(posedge clk);
            if (rsp.arready) begin
                req.arvalid <= 1'b0;
            end
            if (rsp.rvalid) begin
                data = rsp.rdata;
                resp = rsp.rresp;
                req.rready <= 1'b0;
                break;
            end
        end
        gone(i < 20);
    endtask

    // wake pins are dropped after a few cycles; count runs to cpu clock restart
    task automatic wait_cpu(output int cnt);
        cnt = 0;
        while (ctl.cpu_clk_run !== 1'b1 && cnt < 20000) begin
            @(posedge clk);
            cnt++;
            if (cnt == 4) begin
                external_irq_zero <= 1'b0;
                irq_req <= 1'b0;
            end
        end
        gone(cnt < 20000);
    endtask

    task automatic wait_sfr(output int cnt);
        for (cnt = 1; cnt < 40 && ctl.sfr_reset !== 1'b0; cnt++) begin
            @(posedge clk);
        end
        gone(cnt < 40);
    endtask

    function automatic logic [31:0] in_range(input int v, input int lo, input int hi);
        return 32'(v >= lo && v <= hi);
    endfunction

    initial begin
        repeat (100000) @(posedge clk);
        n_fail++;
        test_done();
    end

    initial begin
        seed = 32'h8936bbb1;
        n_fail = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        reset_pin_n = 1'b1;
        external_irq_zero = 1'b0;
        irq_req = 1'b0;
        req = '0;
        tab = '{ssw_pkg::IDX_CLK_STOP_SEL, ssw_pkg::IDX_PORT_CTL2, ssw_pkg::IDX_CPU_MODE};
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge clk);
        wait_sfr(n);
        for (k = 0; k < 3; k++) begin
            rd(tab[k], d, r);
            check(d, 32'h0);
            check(32'(r), 32'(ssw_pkg::RESP_OKAY));
        end
        rd(ssw_pkg::IDX_STAB, d, r);
        check(d, 32'h0000_01ff);
        rd(8'h00, d, r);
        check(32'(r), 32'(ssw_pkg::RESP_DECERR));
        for (k = 0; k < 3; k++) begin
            q = $random(seed) & 32'hff;
            wr(ssw_pkg::IDX_PORT_CTL2, q);
            rd(ssw_pkg::IDX_PORT_CTL2, d, r);
            check(d, q);
        end
        // wait mode with the two-wire keep bit both ways, then interrupt wake
        for (k = 0; k < 2; k++) begin
            wr(ssw_pkg::IDX_CLK_STOP_SEL, 32'(k) << ssw_pkg::BIT_TWO_WIRE_KEEP);
            wr(ssw_pkg::IDX_CMD, 32'h1 << ssw_pkg::BIT_CMD_CPU_GATE);
            repeat (2) @(posedge clk);
            #1;
            check(32'(ctl.cpu_clk_run), 32'h0);
            check(32'({ctl.main_osc_en, ctl.periph_run, ctl.port_hold, ctl.dac_hold}), 32'hf);
            check(32'(ctl.two_wire_run), 32'(k));
            @(posedge clk);
            irq_req <= 1'b1;
            for (n = 0; n < 20 && irq_accept !== 1'b1; n++) begin
                @(posedge clk);
            end
            irq_req <= 1'b0;
            gone(n < 20);
            #1;
            check(32'(ctl.cpu_clk_run), 32'h1);
        end
        // stop with automatic preset, sub oscillator running before entry
        wr(ssw_pkg::IDX_PORT_CTL2, 32'h0);
        wr(ssw_pkg::IDX_CPU_MODE, 32'h1 << ssw_pkg::BIT_SUB_ON);
        wr(ssw_pkg::IDX_STAB, $random(seed) & 32'hffff);
        wr(ssw_pkg::IDX_CMD, 32'h1 << ssw_pkg::BIT_CMD_HALT_OSC);
        rd(ssw_pkg::IDX_STAB, d, r);
        check(d, 32'h0000_01ff);
        check(32'({ctl.main_osc_en, ctl.sub_osc_en, ctl.periph_run}), 32'h0);
        @(posedge clk);
        external_irq_zero <= 1'b1;
        wait_cpu(n);
        base = ssw_pkg::STAB_SRC_DIV * 256 * 2;
        check(in_range(n, base - 32, base + 32), 32'h1);
        check(32'(ctl.sub_osc_en), 32'h1);
        // inhibited preset keeps the short software values
        wr(ssw_pkg::IDX_PORT_CTL2, 32'h1 << ssw_pkg::BIT_STAB_INHIBIT);
        wr(ssw_pkg::IDX_STAB, 32'h0203);
        wr(ssw_pkg::IDX_CMD, 32'h1 << ssw_pkg::BIT_CMD_HALT_OSC);
        rd(ssw_pkg::IDX_STAB, d, r);
        check(d, 32'h0000_0203);
        @(posedge clk);
        irq_req <= 1'b1;
        wait_cpu(n);
        base = ssw_pkg::STAB_SRC_DIV * 4 * 3;
        check(in_range(n, base - 32, base + 32), 32'h1);
        // wait on sub clock with main stopped, ended by a long reset pin low
        wr(ssw_pkg::IDX_CPU_MODE, 32'h7);
        wr(ssw_pkg::IDX_CMD, 32'h1 << ssw_pkg::BIT_CMD_CPU_GATE);
        repeat (2) @(posedge clk);
        #1;
        check(32'({ctl.main_osc_en, ctl.sub_osc_en, ctl.sys_clk_sub}), 32'h3);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (24) @(posedge clk);
        #1;
        check(32'({ctl.main_osc_en, ctl.sub_osc_en, ctl.sys_clk_sub}), 32'h4);
        check(32'({ctl.port_input, ctl.cpu_clk_run, ctl.sfr_reset}), 32'h7);
        @(posedge clk);
        reset_pin_n <= 1'b1;
        wait_sfr(n);
        check(in_range(n, 12, 22), 32'h1);
        rd(ssw_pkg::IDX_CPU_MODE, d, r);
        check(d, 32'h0);
        // a pin low shorter than the reset count leaves registers alone
        wr(ssw_pkg::IDX_CPU_MODE, 32'h2);
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        reset_pin_n <= 1'b1;
        repeat (30) @(posedge clk);
        rd(ssw_pkg::IDX_CPU_MODE, d, r);
        check(d, 32'h2);
        test_done();
    end
endmodule
